/* verilog/tiv_defines.svh */
// Register offsets, field positions, vectors and reset values of the vectoring block.
`ifndef TIV_DEFINES_SVH
`define TIV_DEFINES_SVH

`define TIV_ADDR_SOFT     8'h00
`define TIV_ADDR_LC       8'h04
`define TIV_ADDR_ERR      8'h08
`define TIV_ADDR_STWORD   8'h0c
`define TIV_ADDR_MAP      8'h10
`define TIV_ADDR_STAT     8'h14

`define TIV_LC_EN_BIT     6
`define TIV_TRACE_BIT     4
`define TIV_ERR_RED       2
`define TIV_ERR_YEL       3
`define TIV_ERR_TMO       4
`define TIV_ERR_ADR       6
`define TIV_ERR_HLT       7

`define TIV_RST16         16'h0000
`define TIV_RST8          8'h00

`define TIV_VEC_STACK     16'h0004
`define TIV_VEC_MAP       16'h00a8
`define TIV_VEC_PAR       16'h004c
`define TIV_VEC_TRACE     16'h000c
`define TIV_VEC_POWER     16'h0014
`define TIV_VEC_FLOAT     16'h00a4
`define TIV_VEC_SOFT      16'h00a0
`define TIV_VEC_LINE      16'h0040
`define TIV_VEC_TRAP      16'h001c
`define TIV_VEC_EMUL      16'h0018
`define TIV_VEC_IO        16'h0010
`define TIV_VEC_BRK       16'h000c
`define TIV_VEC_SUPV      16'h0008
`define TIV_VEC_HALT      16'h0004

`define TIV_IDX_MAP       5'h02
`define TIV_IDX_SYNC      5'h09
`define TIV_IDX_MASK      5'h0a
`define TIV_IDX_LINE      5'h0d

`endif

/* verilog/tiv_pkg.sv */
// Types shared by the vectoring block.
package tiv_pkg;

    typedef enum logic [1:0] {
        tiv_idle = 2'b00,
        tiv_ack  = 2'b01,
        tiv_trap = 2'b10
    } tiv_state_t;

    typedef logic [4:0] tiv_idx_t;

endpackage

/* verilog/tiv_first_set.sv */
// Fixed-order priority picker: the lowest set index wins.
`timescale 1ns/1ps
`default_nettype none

module tiv_first_set #(
    parameter int N = 22,
    parameter int W = 5
) (
    input  wire logic [N-1:0] req,
    output logic              found,
    output logic [W-1:0]      idx
);

    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = W'(i);
            end
        end
    end

endmodule

`default_nettype wire

/* verilog/tiv_vector_ctrl.sv */
// Trap and interrupt prioritisation and vectoring with an AHB-Lite port.
// Overview of operation
// - Four hardware request lines, levels 4 to 7, vector from requester.
// - Seven software levels from the soft request register, vector 240.
// - Soft level 7 from bit 15, priority 7, vector 240.
// - Soft level 6 from bit 14 arbitrates at priority 7.
// - Soft levels 5 to 1 from bits 13 to 9, priority equals level.
// - Red/yellow stack, address error, timeout trap via 4 and flag.
// - Mapping violation, status bits 13 to 15, traps via 250.
// - Trace bit 4 of status word set gives trace trap via 14.
// - External parity error or abort traps via 114.
// - Halt line takes no vector and enters console mode.
// - Halt line lowest normally, highest while a vector is read.
// - General trap to 34, emulator trap to 30, I/O trap to 20.
// - Breakpoint trap instruction vectors through 14.
// - Call-to-supervisor instruction vectors through 10.
// - Kernel halt: console with jumper, else emergency stack, vector 4.
// - Halt outside kernel is illegal: vector 4, error bit 7.
// - Soft register bits 7:5 and 3:1 read highest level set.
// - Line clock bit 6 lets line event raise level 6 via 100.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tiv_defines.svh"

module tiv_vector_ctrl (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [3:0]  irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic        irq_vec_valid,
    output logic [3:0]       irq_ack,
    input  wire logic        line_event_input,
    input  wire logic        red_stack_in,
    input  wire logic        yellow_stack_in,
    input  wire logic        addr_error_in,
    input  wire logic [1:0]  timeout_in,
    input  wire logic [2:0]  map_abort_in,
    input  wire logic        parity_abort_in,
    input  wire logic        power_fail_input,
    input  wire logic        float_exception_input,
    input  wire logic        instr_done,
    input  wire logic        general_trap_instr,
    input  wire logic        emulator_trap_instr,
    input  wire logic        io_trap_instr,
    input  wire logic        breakpoint_trap_instr,
    input  wire logic        call_supervisor_instr,
    input  wire logic        halt_instr,
    input  wire logic        halt_option_jumper,
    input  wire logic        halt_line,
    input  wire logic        vector_read,
    input  wire logic        console_start,
    input  wire logic        reset_instr,
    input  wire logic        trap_done,
    output logic             trap_req,
    output logic [15:0]      trap_vector,
    output logic             emergency_stack,
    output logic             console_monitor_mode
);

    tiv_pkg::tiv_state_t state;
    tiv_pkg::tiv_idx_t   cur_idx;
    tiv_pkg::tiv_idx_t   win_idx;
    logic [6:0]          soft_req;
    logic                lc_enable;
    logic [7:0]          err_reg;
    logic [15:0]         stat_word;
    logic [2:0]          map_stat;
    logic [8:0]          pend_nm;
    logic                sync_pend;
    logic [15:0]         sync_vec;
    logic                sync_esr;
    logic                pend_line;
    logic                wr_pend;
    logic [7:0]          wr_addr;

    function automatic logic [2:0] top_level(input logic [6:0] r);
        top_level = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (r[i]) begin
                top_level = 3'(i + 1);
            end
        end
    endfunction

    function automatic logic [2:0] lvl_of(input logic [4:0] i);
        case (i)
            5'h0a, 5'h0b, 5'h0c: lvl_of = 3'h7;
            5'h0d, 5'h0e:        lvl_of = 3'h6;
            5'h0f, 5'h10:        lvl_of = 3'h5;
            5'h11, 5'h12:        lvl_of = 3'h4;
            5'h13:               lvl_of = 3'h3;
            5'h14:               lvl_of = 3'h2;
            5'h15:               lvl_of = 3'h1;
            default:             lvl_of = 3'h0;
        endcase
    endfunction

    function automatic logic [1:0] line_of(input logic [4:0] i);
        case (i)
            5'h0b:   line_of = 2'h3;
            5'h0e:   line_of = 2'h2;
            5'h10:   line_of = 2'h1;
            default: line_of = 2'h0;
        endcase
    endfunction

    function automatic logic [15:0] vec_of(input logic [4:0] i,
                                           input logic [15:0] sv);
        case (i)
            5'h00, 5'h01, 5'h03, 5'h06: vec_of = `TIV_VEC_STACK;
            5'h02:   vec_of = `TIV_VEC_MAP;
            5'h04:   vec_of = `TIV_VEC_PAR;
            5'h05:   vec_of = `TIV_VEC_TRACE;
            5'h07:   vec_of = `TIV_VEC_POWER;
            5'h08:   vec_of = `TIV_VEC_FLOAT;
            5'h09:   vec_of = sv;
            5'h0d:   vec_of = `TIV_VEC_LINE;
            default: vec_of = `TIV_VEC_SOFT;
        endcase
    endfunction

    wire logic        ahb_go  = hsel && htrans[1] && hready;
    wire logic [2:0]  soft_top = top_level(soft_req);
    wire logic [2:0]  cur_prio = stat_word[7:5];
    wire logic        kernel   = (stat_word[15:14] == 2'b00);
    wire logic        wr_soft  = wr_pend && (wr_addr == `TIV_ADDR_SOFT);
    wire logic        wr_lc    = wr_pend && (wr_addr == `TIV_ADDR_LC);
    wire logic        wr_err   = wr_pend && (wr_addr == `TIV_ADDR_ERR);
    wire logic        wr_stw   = wr_pend && (wr_addr == `TIV_ADDR_STWORD);
    wire logic        wr_map   = wr_pend && (wr_addr == `TIV_ADDR_MAP);
    wire logic        lc_clear = console_start || reset_instr;
    wire logic        halt_k   = halt_instr && kernel;
    wire logic        halt_con = halt_k && halt_option_jumper;
    wire logic        halt_esr = halt_k && !halt_option_jumper;
    wire logic        halt_ill = halt_instr && !kernel;
    wire logic [15:0] soft_rd  = {soft_req, 1'b0, soft_top, 1'b0,
                                  soft_top, 1'b0};
    wire logic [15:0] stat_rd  = {console_monitor_mode, (state !=
                                  tiv_pkg::tiv_idle), 5'h00,
                                  trap_vector[8:0]};

    wire logic [15:0] rd_mux =
        (haddr[7:0] == `TIV_ADDR_SOFT) ? soft_rd :
        (haddr[7:0] == `TIV_ADDR_LC)   ? {9'h000, lc_enable, 6'h00} :
        (haddr[7:0] == `TIV_ADDR_ERR)  ? {8'h00, err_reg} :
        (haddr[7:0] == `TIV_ADDR_STWORD) ? stat_word :
        (haddr[7:0] == `TIV_ADDR_MAP)  ? {map_stat, 13'h0000} :
        (haddr[7:0] == `TIV_ADDR_STAT) ? stat_rd : 16'h0000;

    // Maskable sources in order: equal levels put software before hardware, except soft level 6, which follows hardware level 7.
    wire logic [11:0] raw_m = {soft_req[0], soft_req[1], soft_req[2],
                               irq_req[0], soft_req[3], irq_req[1],
                               soft_req[4], irq_req[2], pend_line,
                               soft_req[5], irq_req[3], soft_req[6]};
    logic [21:0] elig;
    logic        found;

    assign elig[8:0] = pend_nm;
    assign elig[9]   = sync_pend;
    for (genvar g = 0; g < 12; g++) begin : g_mask
        assign elig[10 + g] = raw_m[g] &&
            (lvl_of(5'(10 + g)) > cur_prio);
    end

    tiv_first_set #(
        .N (22),
        .W (5)
    ) u_pick (
        .req   (elig),
        .found (found),
        .idx   (win_idx)
    );

    wire logic take   = (state == tiv_pkg::tiv_idle) && found;
    wire logic is_hw  = (win_idx == 5'h0b) || (win_idx == 5'h0e) ||
                        (win_idx == 5'h10) || (win_idx == 5'h12);
    wire logic [8:0] clr_nm = (take && (win_idx < `TIV_IDX_SYNC)) ?
                              9'(9'h001 << win_idx) : 9'h000;
    wire logic [8:0] set_nm = {float_exception_input, power_fail_input,
                               yellow_stack_in,
                               instr_done && stat_word[`TIV_TRACE_BIT],
                               parity_abort_in, |timeout_in,
                               |map_abort_in, addr_error_in,
                               red_stack_in};
    wire logic sync_any = general_trap_instr || emulator_trap_instr ||
                          io_trap_instr || breakpoint_trap_instr ||
                          call_supervisor_instr || halt_esr || halt_ill;
    wire logic [15:0] sync_sel =
        general_trap_instr    ? `TIV_VEC_TRAP :
        emulator_trap_instr   ? `TIV_VEC_EMUL :
        io_trap_instr         ? `TIV_VEC_IO :
        breakpoint_trap_instr ? `TIV_VEC_BRK :
        call_supervisor_instr ? `TIV_VEC_SUPV :
        `TIV_VEC_HALT;
    wire logic [7:0] set_err = {halt_ill, addr_error_in, timeout_in,
                                yellow_stack_in, red_stack_in,
                                2'b00};
    wire logic [7:0] clr_err = wr_err ? hwdata[7:0] : 8'h00;
    wire logic [2:0] clr_map = wr_map ? hwdata[15:13] : 3'h0;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= `TIV_RST8;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= ahb_go && hwrite;
            wr_addr   <= haddr[7:0];
            hrdata    <= (ahb_go && !hwrite) ? {16'h0000, rd_mux} : '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Hardware sets win over software clears on the sticky flags.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            soft_req  <= 7'h00;
            lc_enable <= 1'b0;
            stat_word <= `TIV_RST16;
            err_reg   <= `TIV_RST8;
            map_stat  <= 3'h0;
            pend_nm   <= 9'h000;
            pend_line <= 1'b0;
        end else begin
            soft_req  <= wr_soft ? hwdata[15:9] : soft_req;
            lc_enable <= lc_clear ? 1'b0 :
                         wr_lc ? hwdata[`TIV_LC_EN_BIT] : lc_enable;
            stat_word <= wr_stw ? hwdata[15:0] : stat_word;
            err_reg   <= (err_reg & ~clr_err) | set_err;
            map_stat  <= (map_stat & ~clr_map) | map_abort_in;
            pend_nm   <= (pend_nm & ~clr_nm) | set_nm;
            pend_line <= (pend_line && !(take &&
                         (win_idx == `TIV_IDX_LINE))) ||
                         (line_event_input && lc_enable);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync_pend <= 1'b0;
            sync_vec  <= `TIV_RST16;
            sync_esr  <= 1'b0;
        end else if (sync_any) begin
            sync_pend <= 1'b1;
            sync_vec  <= sync_sel;
            sync_esr  <= halt_esr && !(general_trap_instr ||
                         emulator_trap_instr || io_trap_instr ||
                         breakpoint_trap_instr || call_supervisor_instr);
        end else if (take && (win_idx == `TIV_IDX_SYNC)) begin
            sync_pend <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state                <= tiv_pkg::tiv_idle;
            cur_idx              <= 5'h00;
            irq_ack              <= 4'h0;
            trap_req             <= 1'b0;
            trap_vector          <= `TIV_RST16;
            emergency_stack      <= 1'b0;
            console_monitor_mode <= 1'b0;
        end else begin
            if (console_start) begin
                console_monitor_mode <= 1'b0;
            end else if (halt_con) begin
                console_monitor_mode <= 1'b1;
            end
            case (state)
                tiv_pkg::tiv_idle: begin
                    if (found && is_hw) begin
                        cur_idx <= win_idx;
                        irq_ack <= 4'h1 << line_of(win_idx);
                        state   <= tiv_pkg::tiv_ack;
                    end else if (found) begin
                        cur_idx         <= win_idx;
                        trap_req        <= 1'b1;
                        trap_vector     <= vec_of(win_idx, sync_vec);
                        emergency_stack <= (win_idx == `TIV_IDX_SYNC) &&
                                           sync_esr;
                        state           <= tiv_pkg::tiv_trap;
                    end else if (halt_line) begin
                        console_monitor_mode <= 1'b1;
                    end
                end
                tiv_pkg::tiv_ack: begin
                    if (irq_vec_valid) begin
                        irq_ack     <= 4'h0;
                        trap_req    <= 1'b1;
                        trap_vector <= irq_vector;
                        state       <= tiv_pkg::tiv_trap;
                    end else if (!irq_req[line_of(cur_idx)]) begin
                        irq_ack <= 4'h0;
                        state   <= tiv_pkg::tiv_idle;
                    end
                end
                tiv_pkg::tiv_trap: begin
                    if (halt_line && vector_read) begin
                        trap_req             <= 1'b0;
                        emergency_stack      <= 1'b0;
                        console_monitor_mode <= 1'b1;
                        state                <= tiv_pkg::tiv_idle;
                    end else if (trap_done) begin
                        trap_req        <= 1'b0;
                        emergency_stack <= 1'b0;
                        state           <= tiv_pkg::tiv_idle;
                    end
                end
                default: begin
                    state <= tiv_pkg::tiv_idle;
                end
            endcase
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_soft_vector: assert property (
        trap_req && (cur_idx >= `TIV_IDX_MASK) && !(cur_idx == 5'h0b ||
        cur_idx == 5'h0d || cur_idx == 5'h0e || cur_idx == 5'h10 ||
        cur_idx == 5'h12) |-> trap_vector == `TIV_VEC_SOFT)
        else $error("Soft request not vectored through 240.");
    a_enc_level: assert property (
        soft_req[6] |-> soft_top == 3'h7 && soft_rd[7:5] == soft_rd[3:1])
        else $error("Encoded soft level wrong.");
    a_stack_vector: assert property (
        trap_req && (cur_idx == 5'h00 || cur_idx == 5'h01 ||
        cur_idx == 5'h03 || cur_idx == 5'h06) |-> trap_vector == 16'h0004)
        else $error("Error trap not vectored through 4.");
    a_map_vector: assert property (
        trap_req && cur_idx == `TIV_IDX_MAP |-> trap_vector == 16'h00a8)
        else $error("Mapping trap not vectored through 250.");
    a_mask_level: assert property (
        $rose(state != tiv_pkg::tiv_idle) && cur_idx >= `TIV_IDX_MASK
        |-> lvl_of(cur_idx) > $past(cur_prio) && $past(pend_nm) == 9'h000)
        else $error("Maskable request granted below priority.");
    a_vector_capture: assert property (
        state == tiv_pkg::tiv_ack && irq_vec_valid |-> irq_ack != 4'h0
        ##1 trap_req && trap_vector == $past(irq_vector) && irq_ack == 4'h0)
        else $error("Requester vector not captured after acknowledge.");
    a_halt_vecread: assert property (
        state == tiv_pkg::tiv_trap && halt_line && vector_read
        |=> console_monitor_mode && !trap_req)
        else $error("Halt line lost during vector read.");
    a_illegal_halt: assert property (
        halt_instr && !kernel |=> err_reg[7] && sync_pend &&
        sync_vec == 16'h0004)
        else $error("Illegal halt not flagged.");
    a_line_clear: assert property (
        console_start || reset_instr |=> !lc_enable)
        else $error("Line clock register not cleared.");

endmodule

`default_nettype wire

/* dv/tiv_periph.sv */
// Bus peripheral model that raises hardware requests and supplies vectors.
`timescale 1ns/1ps
`default_nettype none
module tiv_periph (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [3:0]  raise,
    input  wire logic [1:0]  lag,
    input  wire logic [15:0] base,
    input  wire logic [3:0]  irq_ack,
    output logic      [3:0]  irq_req,
    output logic      [15:0] irq_vector,
    output logic             irq_vec_valid
);
    logic [1:0]  cnt;
    logic [15:0] vec;
    assign vec = base + {12'h0, irq_ack[3] | irq_ack[2],
                         irq_ack[3] | irq_ack[1], 2'b00};
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_req <= 4'h0;
            cnt <= 2'h0;
            irq_vec_valid <= 1'b0;
            irq_vector <= 16'h0;
        end else if (irq_vec_valid && irq_ack != 4'h0) begin
            irq_req <= (irq_req | raise) & ~irq_ack;
            irq_vec_valid <= 1'b0;
            irq_vector <= ~irq_vector;
        end else if (irq_ack != 4'h0 && !irq_vec_valid) begin
            irq_req <= irq_req | raise;
            cnt <= (cnt == lag) ? 2'h0 : cnt + 2'h1;
            irq_vec_valid <= (cnt == lag);
            irq_vector <= (cnt == lag) ? vec : ~irq_vector;
        end else begin
            irq_req <= irq_req | raise;
            irq_vec_valid <= 1'b0;
            irq_vector <= ~irq_vector;
        end
    end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the trap and interrupt vectoring block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        mclk, rstn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0]  htrans, lag;
    logic [3:0]  irq_req, irq_ack, raise;
    logic [15:0] irq_vector, base, trap_vector;
    logic [6:0]  err_src, m;
    logic [4:0]  ins;
    logic [2:0]  map_abort_in;
    logic        irq_vec_valid, line_event_input, parity_abort_in;
    logic        instr_done, halt_instr, halt_option_jumper, halt_line;
    logic        vector_read, console_start, reset_instr, trap_done;
    logic        trap_req, emergency_stack, console_monitor_mode;
    int          miscompares, total_checks, cycles, seed;

    tiv_vector_ctrl tiv_vector_ctrl_inst (
        .mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .irq_req, .irq_vector, .irq_vec_valid, .irq_ack, .line_event_input,
        .red_stack_in(err_src[6]), .yellow_stack_in(err_src[5]),
        .addr_error_in(err_src[4]), .timeout_in(err_src[3:2]),
        .map_abort_in, .parity_abort_in, .power_fail_input(err_src[1]),
        .float_exception_input(err_src[0]), .instr_done,
        .general_trap_instr(ins[4]), .emulator_trap_instr(ins[3]),
        .io_trap_instr(ins[2]), .breakpoint_trap_instr(ins[1]),
        .call_supervisor_instr(ins[0]), .halt_instr, .halt_option_jumper,
        .halt_line, .vector_read, .console_start, .reset_instr, .trap_done,
        .trap_req, .trap_vector, .emergency_stack, .console_monitor_mode
    );
    tiv_periph tiv_periph_inst (.mclk, .rstn, .raise, .lag, .base,
        .irq_ack, .irq_req, .irq_vector, .irq_vec_valid);

    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rdat = hrdata;
        chk(hresp, 0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 32'h0);
        chk(rdat, e);
    endtask

    task automatic wait_trap(input logic [15:0] v);
        int n;
        n = 0;
        while (trap_req !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(trap_req, 1);
        chk(trap_vector, v);
    endtask

    task automatic done;
        @(posedge mclk) trap_done <= 1;
        @(posedge mclk) trap_done <= 0;
    endtask

    task automatic hw_take(input int i);
        int n;
        n = 0;
        while (irq_ack === 4'h0 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(irq_ack, 4'h1 << i);
        wait_trap(base + 16'(i * 4));
        done;
    endtask

    task automatic idle_chk(input logic con);
        repeat (3) @(posedge mclk);
        #1;
        chk(trap_req, 0);
        chk(console_monitor_mode, con);
    endtask

    function automatic logic [31:0] soft_exp(input logic [6:0] k);
        logic [2:0] l;
        l = 0;
        for (int i = 0; i < 7; i++) if (k[i]) l = 3'(i + 1);
        return {16'h0, k, 1'b0, l, 1'b0, l, 1'b0};
    endfunction

    function automatic logic [31:0] err_bit(input int k);
        return k == 0 ? 32'h4 : k == 1 ? 32'h8 : k == 2 ? 32'h40 :
               k == 3 ? 32'h20 : k == 4 ? 32'h10 : 32'h0;
    endfunction

    function automatic logic [15:0] ins_vec(input int k);
        return k == 0 ? 16'h1c : k == 1 ? 16'h18 : k == 2 ? 16'h10 :
               k == 3 ? 16'hc : 16'h8;
    endfunction

    initial begin
        {rstn, hsel, hwrite, haddr, hwdata, htrans, lag, raise, base} = 0;
        {err_src, ins, map_abort_in, line_event_input, parity_abort_in} = 0;
        {instr_done, halt_instr, halt_option_jumper, halt_line} = 0;
        {vector_read, console_start, reset_instr, trap_done} = 0;
        {miscompares, total_checks, cycles} = 0;
        seed = 32'hf719;
        repeat (5) @(posedge mclk);
        rstn <= 1;
        @(posedge mclk);
        #1;
        chk(hreadyout, 1);
        for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0);
        wr(8'h18, 32'hffff);
        rd(8'h18, 32'h0);
        wr(8'h0c, 32'he0);
        rd(8'h0c, 32'he0);
        repeat (4) begin
            m = 7'($random(seed));
            wr(8'h00, {16'h0, m, 9'h0});
            rd(8'h00, soft_exp(m));
            idle_chk(0);
        end
        wr(8'h00, 32'h0);
        wr(8'h0c, 32'h0);
        for (int lv = 1; lv < 8; lv++) begin
            wr(8'h00, 32'h1 << (8 + lv));
            wait_trap(16'ha0);
            wr(8'h0c, 32'(lv) << 5);
            done;
            repeat (3) @(posedge mclk);
            #1;
            chk(trap_req, lv == 6);
            wr(8'h00, 32'h0);
            if (trap_req === 1'b1) done;
            wr(8'h0c, 32'h0);
        end
        for (int k = 0; k < 7; k++) begin
            @(posedge mclk) err_src <= 7'h40 >> k;
            @(posedge mclk) err_src <= 0;
            wait_trap(k < 5 ? 16'h4 : k == 5 ? 16'h14 : 16'ha4);
            done;
            rd(8'h08, err_bit(k));
            wr(8'h08, 32'hff);
        end
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk) ins <= 5'h10 >> k;
            @(posedge mclk) ins <= 0;
            wait_trap(ins_vec(k));
            done;
        end
        m = 7'(($random(seed) & 3) + 1);
        @(posedge mclk) map_abort_in <= m[2:0];
        @(posedge mclk) map_abort_in <= 0;
        wait_trap(16'ha8);
        done;
        rd(8'h10, 32'(m[2:0]) << 13);
        wr(8'h10, 32'he000);
        @(posedge mclk) parity_abort_in <= 1;
        @(posedge mclk) parity_abort_in <= 0;
        wait_trap(16'h4c);
        done;
        wr(8'h0c, 32'h10);
        @(posedge mclk) instr_done <= 1;
        @(posedge mclk) instr_done <= 0;
        wait_trap(16'hc);
        wr(8'h0c, 32'h0);
        done;
        wr(8'h04, 32'h40);
        rd(8'h04, 32'h40);
        @(posedge mclk) line_event_input <= 1;
        @(posedge mclk) line_event_input <= 0;
        wait_trap(16'h40);
        done;
        @(posedge mclk) reset_instr <= 1;
        @(posedge mclk) reset_instr <= 0;
        rd(8'h04, 32'h0);
        repeat (2) begin
            lag <= 2'($random(seed));
            base <= 16'($random(seed)) & 16'hfff0;
            raise <= 4'hf;
            @(posedge mclk) raise <= 0;
            for (int i = 3; i >= 0; i--) hw_take(i);
        end
        halt_option_jumper <= 1;
        @(posedge mclk) halt_instr <= 1;
        @(posedge mclk) halt_instr <= 0;
        idle_chk(1);
        @(posedge mclk) console_start <= 1;
        @(posedge mclk) console_start <= 0;
        halt_option_jumper <= 0;
        @(posedge mclk) halt_instr <= 1;
        @(posedge mclk) halt_instr <= 0;
        wait_trap(16'h4);
        chk(emergency_stack, 1);
        done;
        wr(8'h0c, 32'hc000);
        @(posedge mclk) halt_instr <= 1;
        @(posedge mclk) halt_instr <= 0;
        wait_trap(16'h4);
        chk(emergency_stack, 0);
        done;
        rd(8'h08, 32'h80);
        wr(8'h08, 32'h80);
        wr(8'h0c, 32'h0);
        halt_line <= 1;
        idle_chk(1);
        @(posedge mclk) {halt_line, console_start} <= 2'b01;
        @(posedge mclk) console_start <= 0;
        wr(8'h00, 32'h200);
        halt_line <= 1;
        wait_trap(16'ha0);
        rd(8'h14, 32'h40a0);
        wr(8'h00, 32'h0);
        {vector_read, halt_line} <= 2'b11;
        idle_chk(1);
        end_of_test;
    end
endmodule
`default_nettype wire
